// File: hdl/cpu_exception_and_reset_entry.sv
`timescale 1ns/1ps
`include "exc_cfg.svh"

module cpu_exception_and_reset_entry (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 power_on_clear_in_n,
    input  wire exc_pkg::decode_req_t dec,
    output logic                      decode_done,
    output logic                      decode_fault,
    input  wire logic                 into_valid,
    input  wire logic [15:0]          into_next_ip,
    input  wire exc_pkg::bound_req_t  bound,
    input  wire logic                 instr_boundary,
    input  wire logic [15:0]          boundary_ip,
    input  wire logic                 interrupt_return,
    input  wire logic [15:0]          interrupt_return_status,
    input  wire logic                 flags_wr,
    input  wire logic [15:0]          flags_wr_data,
    input  wire exc_pkg::mask_src_t   irq_src,
    input  wire logic                 nmi_req,
    output logic                      irq_ack,
    output logic [7:0]                irq_ack_vector,
    output exc_pkg::entry_t           entry,
    output logic [15:0]               status_word,
    output logic                      cpu_run,
    output logic                      bus_enable,
    output logic                      fetch_start,
    output logic [19:0]               fetch_addr,
    output logic                      init_load,
    output exc_pkg::init_regs_t       init_regs,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      irq_o
);

    // signed comparison, both bounds inclusive
    function automatic logic out_of_range(input logic [15:0] idx,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        out_of_range = ($signed(idx) < $signed(lo)) || ($signed(idx) > $signed(hi));
    endfunction

    // fixed order: timer, dma0, dma1, then pins 0..3
    function automatic logic [8:0] pick_maskable(input exc_pkg::mask_src_t s);
        logic [8:0] r;
        r = 9'h000;
        for (int i = 3; i >= 0; i--) begin
            if (s.ext_pins[i]) begin
                r = {1'h1, `VEC_PIN0 + 8'(i)};
            end
        end
        if (s.dma[1]) begin
            r = {1'h1, `VEC_DMA1};
        end
        if (s.dma[0]) begin
            r = {1'h1, `VEC_DMA0};
        end
        if (s.timer) begin
            r = {1'h1, `VEC_TIMER};
        end
        return r;
    endfunction

    logic is_coproc;
    logic is_undefined;

    exc_opcode_class u_class (
        .opcode       (dec.opcode),
        .is_coproc    (is_coproc),
        .is_undefined (is_undefined)
    );

    exc_pkg::rst_state_t   state_q, state_d;
    logic [`SETTLE_W-1:0]  cnt_q, cnt_d;
    logic [15:0]           status_q, status_d;
    logic                  nmi_pend_q, nmi_pend_d;
    logic                  done_q, done_d;
    logic                  fault_q, fault_d;
    logic                  ack_irq_q, ack_irq_d;
    logic [7:0]            ack_vec_q, ack_vec_d;
    exc_pkg::entry_t       entry_q, entry_d;
    logic                  run_q, run_d;
    logic                  fetch_q, fetch_d;
    logic                  init_q, init_d;
    logic [`EV_W-1:0]      ev_set;

    logic [15:0]           base_status;
    logic                  if_now;
    logic [8:0]            pick;
    logic                  take;
    logic [7:0]            take_vec;
    logic [15:0]           take_ip;

    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        status_d   = status_q;
        nmi_pend_d = nmi_pend_q | nmi_req;
        done_d     = 1'h0;
        fault_d    = 1'h0;
        ack_irq_d  = 1'h0;
        ack_vec_d  = ack_vec_q;
        entry_d    = entry_q;
        entry_d.valid = 1'h0;
        run_d      = 1'h0;
        fetch_d    = 1'h0;
        init_d     = 1'h0;
        ev_set     = '0;
        take       = 1'h0;
        take_vec   = 8'h00;
        take_ip    = 16'h0000;
        pick       = pick_maskable(irq_src);

        // a return reloads the full word before the enable check and the saved copy look at it; the overflow trap reads status_q
        base_status = status_q;
        if (flags_wr) begin
            base_status = flags_wr_data;
        end
        if (interrupt_return) begin
            base_status = interrupt_return_status;
        end
        if_now = base_status[`IF_BIT];

        unique case (state_q)
            exc_pkg::RST_HOLD: begin
                init_d   = 1'h1;
                status_d = `STATUS_RESET;
                cnt_d    = '0;
                nmi_pend_d = 1'h0;
                if (power_on_clear_in_n) begin
                    state_d = exc_pkg::RST_SETTLE;
                end
            end
            exc_pkg::RST_SETTLE: begin
                cnt_d = cnt_q + `SETTLE_W'(1);
                if (cnt_q == `SETTLE_W'(`SETTLE_CYC - 1)) begin
                    state_d = exc_pkg::RST_RUN;
                    fetch_d = 1'h1;
                    run_d   = 1'h1;
                end
            end
            exc_pkg::RST_RUN: begin
                run_d    = 1'h1;
                status_d = base_status;
                if (dec.valid) begin
                    done_d  = 1'h1;
                    fault_d = is_coproc | is_undefined;
                end
                if (dec.valid && is_coproc) begin
                    take     = 1'h1;
                    take_vec = `VEC_ESC;
                    take_ip  = dec.seg_prefix ? dec.prefix_ip : dec.op_ip;
                    ev_set[`EV_ESC] = 1'h1;
                end else if (dec.valid && is_undefined) begin
                    take     = 1'h1;
                    take_vec = `VEC_UNDEF;
                    take_ip  = dec.next_ip;
                    ev_set[`EV_UNDEF] = 1'h1;
                end else if (bound.valid) begin
                    if (out_of_range(bound.index, bound.lower, bound.upper)) begin
                        take     = 1'h1;
                        take_vec = `VEC_BOUND;
                        take_ip  = bound.next_ip;
                        ev_set[`EV_BOUND] = 1'h1;
                    end
                end else if (into_valid) begin
                    if (status_q[`OF_BIT]) begin
                        take     = 1'h1;
                        take_vec = `VEC_INTO;
                        take_ip  = into_next_ip;
                        ev_set[`EV_INTO] = 1'h1;
                    end
                end else if (instr_boundary) begin
                    // a return is itself a boundary, so a freshly enabled
                    // request is taken before the next instruction
                    if (nmi_pend_q) begin
                        take       = 1'h1;
                        take_vec   = `VEC_NMI;
                        take_ip    = boundary_ip;
                        nmi_pend_d = nmi_req;
                        ev_set[`EV_NMI] = 1'h1;
                    end else if (pick[8] && if_now) begin
                        take      = 1'h1;
                        take_vec  = pick[7:0];
                        take_ip   = boundary_ip;
                        ack_irq_d = 1'h1;
                        ack_vec_d = pick[7:0];
                        ev_set[`EV_MASKABLE] = 1'h1;
                    end
                end
                if (take) begin
                    entry_d.valid        = 1'h1;
                    entry_d.vector       = take_vec;
                    entry_d.table_addr   = {take_vec, 2'h0};
                    entry_d.saved_status = base_status;
                    entry_d.return_ip    = take_ip;
                    status_d[`IF_BIT]    = 1'h0;
                end
            end
        endcase

        // reset pin overrides state, run, fetch, decode, ack, entry and event pulses, mid-instruction included
        if (!power_on_clear_in_n) begin
            state_d  = exc_pkg::RST_HOLD;
            run_d    = 1'h0;
            fetch_d  = 1'h0;
            done_d   = 1'h0;
            fault_d  = 1'h0;
            ack_irq_d = 1'h0;
            entry_d.valid = 1'h0;
            ev_set   = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q    <= exc_pkg::RST_HOLD;
            cnt_q      <= '0;
            status_q   <= `STATUS_RESET;
            nmi_pend_q <= 1'h0;
            done_q     <= 1'h0;
            fault_q    <= 1'h0;
            ack_irq_q  <= 1'h0;
            ack_vec_q  <= 8'h00;
            entry_q    <= '0;
            run_q      <= 1'h0;
            fetch_q    <= 1'h0;
            init_q     <= 1'h1;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            status_q   <= status_d;
            nmi_pend_q <= nmi_pend_d;
            done_q     <= done_d;
            fault_q    <= fault_d;
            ack_irq_q  <= ack_irq_d;
            ack_vec_q  <= ack_vec_d;
            entry_q    <= entry_d;
            run_q      <= run_d;
            fetch_q    <= fetch_d;
            init_q     <= init_d;
        end
    end

    // reset image never changes, kept in flops so outputs stay registered
    exc_pkg::init_regs_t init_regs_q;

    always_ff @(posedge mclk) begin
        init_regs_q.cs                  <= `CS_RESET;
        init_regs_q.ip                  <= `IP_RESET;
        init_regs_q.ds                  <= `SEG_RESET;
        init_regs_q.es                  <= `SEG_RESET;
        init_regs_q.ss                  <= `SEG_RESET;
        init_regs_q.relocation          <= `RELOC_RESET;
        init_regs_q.upper_memory_select <= `UMS_RESET;
    end

    // register bus
    logic [`EV_W-1:0] events_q, events_d;
    logic [`EV_W-1:0] mask_q, mask_d;
    logic             ack_q, ack_d;
    logic [31:0]      dat_q, dat_d;
    logic             irq_q, irq_d;
    logic             wb_hit;

    always_comb begin
        wb_hit   = wb_cyc_i && wb_stb_i && !ack_q;
        ack_d    = wb_hit;
        dat_d    = dat_q;
        mask_d   = mask_q;
        events_d = events_q;
        if (wb_hit && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `ADR_EVENTS) begin
                events_d = events_q & ~wb_dat_i[`EV_W-1:0];
            end
            if (wb_adr_i == `ADR_MASK) begin
                mask_d = wb_dat_i[`EV_W-1:0];
            end
        end
        // set after clear so a same-cycle event survives
        events_d = events_d | ev_set;
        if (wb_hit) begin
            unique case (wb_adr_i)
                `ADR_EVENTS: dat_d = {26'h000_0000, events_q};
                `ADR_MASK:   dat_d = {26'h000_0000, mask_q};
                `ADR_FLAGS:  dat_d = {16'h0000, status_q};
                `ADR_LAST:   dat_d = {entry_q.return_ip, 8'h00, entry_q.vector};
                default:     dat_d = 32'h0000_0000;
            endcase
        end
        irq_d = |(events_q & mask_q);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            events_q <= '0;
            mask_q   <= '0;
            ack_q    <= 1'h0;
            dat_q    <= 32'h0000_0000;
            irq_q    <= 1'h0;
        end else begin
            events_q <= events_d;
            mask_q   <= mask_d;
            ack_q    <= ack_d;
            dat_q    <= dat_d;
            irq_q    <= irq_d;
        end
    end

    assign decode_done    = done_q;
    assign decode_fault   = fault_q;
    assign irq_ack        = ack_irq_q;
    assign irq_ack_vector = ack_vec_q;
    assign entry          = entry_q;
    assign status_word    = status_q;
    assign cpu_run        = run_q;
    assign bus_enable     = run_q;
    assign fetch_start    = fetch_q;
    assign fetch_addr     = `FIRST_FETCH;
    assign init_load      = init_q;
    assign init_regs      = init_regs_q;
    assign wb_dat_o       = dat_q;
    assign wb_ack_o       = ack_q;
    assign irq_o          = irq_q;

endmodule

// File: hdl/exc_cfg.svh
`ifndef EXC_CFG_SVH
`define EXC_CFG_SVH

`define IF_BIT        9
`define OF_BIT        11

`define VEC_NMI       8'h02
`define VEC_INTO      8'h04
`define VEC_BOUND     8'h05
`define VEC_UNDEF     8'h06
`define VEC_ESC       8'h07
`define VEC_TIMER     8'h08
`define VEC_DMA0      8'h0A
`define VEC_DMA1      8'h0B
`define VEC_PIN0      8'h0C

`define STATUS_RESET  16'hF002
`define IP_RESET      16'h0000
`define CS_RESET      16'hFFFF
`define SEG_RESET     16'h0000
`define RELOC_RESET   16'h20FF
`define UMS_RESET     16'hFFFB
`define FIRST_FETCH   20'h0_FFF0

`define ESC_TOP5      5'h1B

`define CLK_NS        100
`define SETTLE_NS     700
`define SETTLE_CYC    ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_W      4

`define ADR_EVENTS    8'h00
`define ADR_MASK      8'h04
`define ADR_FLAGS     8'h08
`define ADR_LAST      8'h0C

`define EV_INTO       0
`define EV_BOUND      1
`define EV_UNDEF      2
`define EV_ESC        3
`define EV_NMI        4
`define EV_MASKABLE   5
`define EV_W          6

`endif

// File: hdl/exc_opcode_class.sv
`timescale 1ns/1ps
`include "exc_cfg.svh"

module exc_opcode_class (
    input  wire logic [7:0] opcode,
    output logic            is_coproc,
    output logic            is_undefined
);

    always_comb begin
        // no mode input on purpose: the trap does not depend on it
        is_coproc = (opcode[7:3] == `ESC_TOP5);
        unique case (opcode)
            8'h0F, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'hD6, 8'hF1: begin
                is_undefined = 1'h1;
            end
            default: begin
                is_undefined = 1'h0;
            end
        endcase
    end

endmodule

// File: hdl/exc_pkg.sv
package exc_pkg;

    typedef enum logic [2:0] {
        RST_HOLD   = 3'h1,
        RST_SETTLE = 3'h2,
        RST_RUN    = 3'h4
    } rst_state_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  opcode;
        logic        seg_prefix;
        logic [15:0] op_ip;
        logic [15:0] prefix_ip;
        logic [15:0] next_ip;
    } decode_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] index;
        logic [15:0] lower;
        logic [15:0] upper;
        logic [15:0] next_ip;
    } bound_req_t;

    typedef struct packed {
        logic [3:0] ext_pins;
        logic [1:0] dma;
        logic       timer;
    } mask_src_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  vector;
        logic [9:0]  table_addr;
        logic [15:0] saved_status;
        logic [15:0] return_ip;
    } entry_t;

    typedef struct packed {
        logic [15:0] cs;
        logic [15:0] ip;
        logic [15:0] ds;
        logic [15:0] es;
        logic [15:0] ss;
        logic [15:0] relocation;
        logic [15:0] upper_memory_select;
    } init_regs_t;

endpackage

// File: test/exc_checker_asserts.sv
`timescale 1ns/1ps
module exc_checker (
    input wire logic                 mclk,
    input wire logic                 rst,
    input wire logic                 power_on_clear_in_n,
    input wire exc_pkg::decode_req_t dec,
    input wire logic                 decode_fault,
    input wire logic                 into_valid,
    input wire logic                 instr_boundary,
    input wire logic                 interrupt_return,
    input wire logic                 flags_wr,
    input wire logic                 irq_ack,
    input wire exc_pkg::entry_t      entry,
    input wire logic [15:0]          status_word,
    input wire logic                 cpu_run,
    input wire logic                 fetch_start,
    input wire logic [19:0]          fetch_addr,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_ack_o
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_esc_trap: assert property (
        dec.valid && cpu_run && power_on_clear_in_n && dec.opcode[7:3] == 5'h1B
        |=> decode_fault && entry.valid && entry.vector == 8'h07 && entry.return_ip ==
        ($past(dec.seg_prefix) ? $past(dec.prefix_ip) : $past(dec.op_ip)))
        else $error("coprocessor opcode not trapped");
    a_vector_addr: assert property (
        entry.valid |-> entry.table_addr == {entry.vector, 2'h0})
        else $error("table address not vector times four");
    a_entry_if: assert property (
        entry.valid |-> !status_word[9])
        else $error("enable flag still set on entry");
    a_mask_gate: assert property (
        instr_boundary && !status_word[9] && !flags_wr && !interrupt_return |=> !irq_ack)
        else $error("maskable request taken while disabled");
    a_into_trap: assert property (
        into_valid && cpu_run && power_on_clear_in_n && status_word[11] && !dec.valid
        |=> entry.valid && entry.vector == 8'h04)
        else $error("overflow trap missing");
    a_into_pass: assert property (
        into_valid && !status_word[11] && !dec.valid && !instr_boundary |=> !entry.valid)
        else $error("overflow trap without overflow");
    a_pin_halt: assert property (
        !power_on_clear_in_n |=> !cpu_run && !fetch_start && !entry.valid)
        else $error("activity while reset pin low");
    a_first_fetch: assert property (
        $rose(fetch_start) |-> cpu_run && fetch_addr == 20'h0_FFF0)
        else $error("first fetch wrong");
    a_wb_ack: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle");
endmodule

bind cpu_exception_and_reset_entry exc_checker chk_i (.*);

// File: test/irq_ctrl_model.sv
`timescale 1ns/1ps
module irq_ctrl_model (
    input wire logic                mclk,
    input wire logic                rst,
    input wire logic [6:0]          raise,
    input wire logic                irq_ack,
    input wire logic [7:0]          irq_ack_vector,
    output exc_pkg::mask_src_t      irq_src
);
    logic [6:0] pend_q;
    logic [6:0] pend_d;
    logic [6:0] clr;

    // a request stays up until its own vector is acknowledged
    always_comb begin
        clr = '0;
        if (irq_ack) begin
            case (irq_ack_vector)
                8'h08: clr[0] = 1'h1;
                8'h0A: clr[1] = 1'h1;
                8'h0B: clr[2] = 1'h1;
                8'h0C, 8'h0D, 8'h0E, 8'h0F: clr[3 + irq_ack_vector[1:0]] = 1'h1;
                default: clr = '0;
            endcase
        end
        pend_d = (pend_q | raise) & ~clr;
    end

    always_ff @(posedge mclk) begin
        pend_q <= rst ? '0 : pend_d;
    end

    assign irq_src = pend_q;
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [7:0]  op;
        logic        seg;
        logic        flt;
        logic [7:0]  vec;
        logic [15:0] ret;
    } row_t;
    localparam row_t ROWS [11] = '{
        '{8'hD8, 1'h0, 1'h1, 8'h07, 16'h1000}, '{8'hDF, 1'h1, 1'h1, 8'h07, 16'h0FFF},
        '{8'hDB, 1'h1, 1'h1, 8'h07, 16'h0FFF}, '{8'h0F, 1'h0, 1'h1, 8'h06, 16'h1002},
        '{8'h63, 1'h0, 1'h1, 8'h06, 16'h1002}, '{8'h67, 1'h1, 1'h1, 8'h06, 16'h1002},
        '{8'hD6, 1'h0, 1'h1, 8'h06, 16'h1002}, '{8'hF1, 1'h0, 1'h1, 8'h06, 16'h1002},
        '{8'hD7, 1'h0, 1'h0, 8'h00, 16'h0000}, '{8'h62, 1'h0, 1'h0, 8'h00, 16'h0000},
        '{8'h68, 1'h0, 1'h0, 8'h00, 16'h0000}};
    localparam logic [15:0] BIDX [3] = '{16'h0010, 16'h000F, 16'hFFFF};

    logic                 mclk, rst, power_on_clear_in_n, into_valid, instr_boundary;
    logic                 interrupt_return, flags_wr, nmi_req, wb_cyc_i, wb_stb_i, wb_we_i;
    logic                 decode_done, decode_fault, irq_ack, cpu_run, bus_enable;
    logic                 fetch_start, init_load, wb_ack_o, irq_o;
    logic [15:0]          into_next_ip, boundary_ip, interrupt_return_status, flags_wr_data, status_word;
    logic [7:0]           wb_adr_i, irq_ack_vector;
    logic [3:0]           wb_sel_i;
    logic [31:0]          wb_dat_i, wb_dat_o, rd;
    logic [19:0]          fetch_addr;
    logic [6:0]           raise;
    exc_pkg::decode_req_t dec;
    exc_pkg::bound_req_t  bound;
    exc_pkg::mask_src_t   irq_src;
    exc_pkg::entry_t      entry;
    exc_pkg::init_regs_t  init_regs;
    int                   n_mismatch, total_checks, n;

    cpu_exception_and_reset_entry dut (.*);
    irq_ctrl_model partner (.mclk(mclk), .rst(rst), .raise(raise), .irq_ack(irq_ack),
        .irq_ack_vector(irq_ack_vector), .irq_src(irq_src));

    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // lets the request edge pass, then drops every pulse input
    task go;
        @(posedge mclk);
        dec.valid <= 1'h0;
        bound.valid <= 1'h0;
        {into_valid, instr_boundary, interrupt_return, flags_wr, nmi_req} <= '0;
        raise <= '0;
        #1;
    endtask

    task wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'hF};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (n == 20) begin
            n_mismatch++;
            finish_test;
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask

    task flags(input logic [15:0] v);
        @(posedge mclk);
        flags_wr <= 1'h1;
        flags_wr_data <= v;
        go;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        finish_test;
    end

    initial begin
        {rst, into_valid, instr_boundary, interrupt_return, flags_wr, nmi_req} = 6'h20;
        power_on_clear_in_n = 1'h0;
        {dec, bound, raise, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {into_next_ip, boundary_ip, interrupt_return_status, flags_wr_data} = '0;
        {n_mismatch, total_checks} = '0;
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        repeat (3) @(posedge mclk);
        #1;
        chk({cpu_run, bus_enable}, 2'h0);
        chk(init_load, 1'h1);
        chk(status_word, 16'hF002);
        chk(init_regs, {16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h20FF, 16'hFFFB});
        @(posedge mclk);
        power_on_clear_in_n <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (fetch_start !== 1'h1 && n < 40);
        chk(n, 8);
        chk({fetch_addr, cpu_run, bus_enable}, {20'h0_FFF0, 2'h3});
        $display("reset test done");

        for (int i = 0; i < 11; i++) begin
            @(posedge mclk);
            dec <= '{1'h1, ROWS[i].op, ROWS[i].seg, 16'h1000, 16'h0FFF, 16'h1002};
            go;
            chk({decode_done, decode_fault, entry.valid}, {1'h1, {2{ROWS[i].flt}}});
            if (ROWS[i].flt) chk({entry.vector, entry.return_ip}, {ROWS[i].vec, ROWS[i].ret});
        end
        $display("decode rows done");

        // undefined and coprocessor events latched, mask still zero
        wb(8'h00, 1'h0, 32'h0000_0000);
        chk({rd, irq_o}, {32'h0000_000C, 1'h0});
        wb(8'h04, 1'h1, 32'h0000_003F);
        wb(8'h08, 1'h0, 32'h0000_0000);
        chk({rd, irq_o}, {32'h0000_F002, 1'h1});
        wb(8'h00, 1'h1, 32'h0000_000C);
        wb(8'h10, 1'h0, 32'h0000_0000);
        chk({rd, irq_o}, {32'h0000_0000, 1'h0});
        $display("register test done");

        flags(16'hF002);
        @(posedge mclk);
        raise <= 7'h01;
        @(posedge mclk);
        {instr_boundary, boundary_ip} <= {1'h1, 16'h2000};
        go;
        chk({irq_ack, entry.valid}, 2'h0);
        flags(16'hF202);
        @(posedge mclk);
        instr_boundary <= 1'h1;
        go;
        chk({irq_ack, irq_ack_vector, entry.table_addr}, {1'h1, 8'h08, 10'h020});
        chk({entry.saved_status, entry.return_ip, status_word[9]}, {32'hF202_2000, 1'h0});
        @(posedge mclk);
        raise <= 7'h02;
        @(posedge mclk);
        instr_boundary <= 1'h1;
        go;
        chk(irq_ack, 1'h0);
        @(posedge mclk);
        {interrupt_return, interrupt_return_status, instr_boundary} <= {1'h1, 16'hF202, 1'h1};
        go;
        chk({irq_ack, irq_ack_vector, entry.saved_status}, {9'h10A, 16'hF202});
        $display("masking test done");

        flags(16'hF802);
        @(posedge mclk);
        {into_valid, into_next_ip} <= {1'h1, 16'h3000};
        go;
        chk({entry.valid, entry.vector, entry.return_ip}, {9'h104, 16'h3000});
        flags(16'hF002);
        @(posedge mclk);
        into_valid <= 1'h1;
        go;
        chk(entry.valid, 1'h0);
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            bound <= '{1'h1, BIDX[i], 16'h0000, 16'h000F, 16'h4000};
            go;
            chk(entry.valid, i != 1);
            if (i != 1) chk({entry.vector, entry.return_ip}, {8'h05, 16'h4000});
        end
        flags(16'hF202);
        @(posedge mclk);
        nmi_req <= 1'h1;
        go;
        @(posedge mclk);
        {instr_boundary, boundary_ip} <= {1'h1, 16'h5000};
        go;
        chk({entry.valid, entry.vector, irq_ack, status_word[9]}, {9'h102, 2'h0});
        $display("exception test done");

        @(posedge mclk);
        power_on_clear_in_n <= 1'h0;
        go;
        @(posedge mclk);
        dec <= '{1'h1, 8'hD8, 1'h0, 16'h1000, 16'h0FFF, 16'h1002};
        go;
        chk({cpu_run, bus_enable, entry.valid, decode_done, fetch_start}, 5'h00);
        @(posedge mclk);
        power_on_clear_in_n <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (fetch_start !== 1'h1 && n < 40);
        chk({n[7:0], status_word, cpu_run}, {8'h08, 16'hF002, 1'h1});
        $display("pin reset test done");
        finish_test;
    end
endmodule
